// *** design/fws_pkg.sv ***
package fws_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_MHZ      = 100;
   localparam int T_ACC_NS     = 90;
   localparam int T_WP_NS      = 50;
   localparam int T_WC_NS      = 90;
   localparam int T_OEH_NS     = 10;
   localparam int T_SLEEP_NS   = 30;
   localparam int T_WINDOW_US  = 50;
   localparam int SYNC_CYC     = 2;
   localparam int ACC_CYC      = (T_ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int WP_CYC       = (T_WP_NS * CLK_MHZ + 999) / 1000;
   localparam int WC_CYC       = (T_WC_NS * CLK_MHZ + 999) / 1000;
   localparam int OEH_CYC      = (T_OEH_NS * CLK_MHZ + 999) / 1000;
   localparam int SLEEP_CYC    = ((T_ACC_NS + T_SLEEP_NS) * CLK_MHZ + 999) / 1000;
   localparam int WINDOW_CYC   = T_WINDOW_US * CLK_MHZ;
   ////////////////////////////////////////////////////////////////////////////////
   // flash bus
   localparam int AW           = 18;
   localparam int DW           = 8;
   localparam logic [7:0] CMD_RESET        = 8'hf0;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
   localparam int BIT_POLL     = 7;
   localparam int BIT_TOGGLE   = 6;
   localparam int BIT_FAIL     = 5;
   localparam int BIT_WINDOW   = 3;
   localparam int BIT_SECTOR   = 2;
   ////////////////////////////////////////////////////////////////////////////////
   // software registers
   localparam logic [2:0] REG_CTRL     = 3'h0;
   localparam logic [2:0] REG_ADDR     = 3'h1;
   localparam logic [2:0] REG_WDATA    = 3'h2;
   localparam logic [2:0] REG_RESULT   = 3'h3;
   localparam logic [2:0] REG_STATUS   = 3'h4;
   localparam logic [2:0] REG_IRQ_STAT = 3'h5;
   localparam logic [2:0] REG_IRQ_MASK = 3'h6;
   localparam logic [2:0] OP_READ      = 3'h1;
   localparam logic [2:0] OP_WRITE     = 3'h2;
   localparam logic [2:0] OP_POLL      = 3'h3;
   localparam logic [2:0] OP_ERASE_ADD = 3'h4;
   localparam int CTRL_SKIP_BIT = 3;
   localparam int RES_FAIL_BIT  = 8;
   localparam int RES_REJ_BIT   = 9;
   localparam int ST_BUSY       = 0;
   localparam int ST_READY      = 1;
   localparam int ST_WINDOW     = 2;
   localparam int ST_SLEEP      = 3;
   localparam int IRQ_W         = 4;
   localparam int IRQ_DONE      = 0;
   localparam int IRQ_FAIL      = 1;
   localparam int IRQ_REJ       = 2;
   localparam int IRQ_RDY       = 3;
   localparam logic [3:0] IRQ_MASK_RST = 4'h0;
   ////////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic          write;
      logic [AW-1:0] addr;
      logic [DW-1:0] data;
   } fws_req_t;
   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] dq_o;
      logic          dq_oe;
      logic          ce_n;
      logic          oe_n;
      logic          we_n;
   } fws_pins_t;
endpackage

// *** design/fws_pin_cycle.sv ***
`timescale 1ns/10ps
module fws_pin_cycle #(
   parameter int RD_CYC  = fws_pkg::ACC_CYC + fws_pkg::SYNC_CYC,
   parameter int WP_CYC  = fws_pkg::WP_CYC,
   parameter int WR_REC  = fws_pkg::WC_CYC - fws_pkg::WP_CYC,
   parameter int RD_REC  = fws_pkg::OEH_CYC
) (
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 reset,
   // request
   input  wire logic                 start,
   input  wire fws_pkg::fws_req_t    req,
   output logic                      done,
   output logic [fws_pkg::DW-1:0]    rdata,
   // flash pins
   output fws_pkg::fws_pins_t        pins,
   input  wire logic [fws_pkg::DW-1:0] dq_i
);
   typedef enum logic [3:0] {
      P_IDLE = 4'b0001,
      P_RD   = 4'b0010,
      P_WR   = 4'b0100,
      P_REC  = 4'b1000
   } fws_pst_t;

   if (RD_CYC < 1 || RD_CYC > 255 || WP_CYC < 1 || WP_CYC > 255 ||
       WR_REC < 1 || WR_REC > 255 || RD_REC < 1 || RD_REC > 255) begin : g_chk
      $error("fws_pin_cycle: cycle counts out of range");
   end

   fws_pst_t                st_r;
   logic [7:0]              cnt_r;
   logic [7:0]              rec_r;
   logic [fws_pkg::DW-1:0]  dq_s1_r;
   logic [fws_pkg::DW-1:0]  dq_s2_r;

   ////////////////////////////////////////////////////////////////////////////////
   // data pin synchroniser
   always_ff @(posedge ref_clk) begin
      dq_s1_r <= dq_i;
      dq_s2_r <= dq_s1_r;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one read or write cycle on the pins
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r       <= P_IDLE;
         cnt_r      <= 8'h00;
         rec_r      <= 8'h00;
         done       <= 1'b0;
         rdata      <= '0;
         pins.addr  <= '0;
         pins.dq_o  <= '0;
         pins.dq_oe <= 1'b0;
         pins.ce_n  <= 1'b1;
         pins.oe_n  <= 1'b1;
         pins.we_n  <= 1'b1;
      end else begin
         done <= 1'b0;
         case (st_r)
            P_IDLE: begin
               if (start) begin
                  pins.addr <= req.addr;
                  pins.ce_n <= 1'b0;
                  cnt_r     <= 8'h00;
                  if (req.write) begin
                     pins.dq_o  <= req.data;
                     pins.dq_oe <= 1'b1;
                     pins.we_n  <= 1'b0;
                     rec_r      <= 8'(WR_REC - 1);
                     st_r       <= P_WR;
                  end else begin
                     pins.oe_n <= 1'b0;
                     rec_r     <= 8'(RD_REC - 1);
                     st_r      <= P_RD;
                  end
               end
            end
            P_RD: begin
               cnt_r <= cnt_r + 8'h01;
               if (cnt_r == 8'(RD_CYC - 1)) begin
                  rdata     <= dq_s2_r;
                  pins.ce_n <= 1'b1;
                  pins.oe_n <= 1'b1;
                  cnt_r     <= 8'h00;
                  st_r      <= P_REC;
               end
            end
            P_WR: begin
               cnt_r <= cnt_r + 8'h01;
               if (cnt_r == 8'(WP_CYC - 1)) begin
                  pins.we_n <= 1'b1;
                  pins.ce_n <= 1'b1;
                  cnt_r     <= 8'h00;
                  st_r      <= P_REC;
               end
            end
            P_REC: begin
               pins.dq_oe <= 1'b0;
               cnt_r      <= cnt_r + 8'h01;
               if (cnt_r == rec_r) begin
                  done <= 1'b1;
                  st_r <= P_IDLE;
               end
            end
            default: st_r <= P_IDLE;
         endcase
      end
   end
endmodule

// *** design/fws_ctrl.sv ***
`timescale 1ns/10ps
module fws_ctrl #(
   parameter int         WINDOW_CYC = fws_pkg::WINDOW_CYC,
   parameter int         SLEEP_CYC  = fws_pkg::SLEEP_CYC,
   parameter logic [7:0] RESET_CMD  = fws_pkg::CMD_RESET,
   parameter logic [7:0] ERASE_CMD  = fws_pkg::CMD_SECTOR_ERASE
) (
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   reset,
   // register port
   input  wire logic [2:0]             reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [31:0]                 reg_rdata,
   // interrupt
   output logic                        irq,
   // flash pins
   output fws_pkg::fws_pins_t          flash_pins,
   input  wire logic [fws_pkg::DW-1:0] flash_dq_i,
   input  wire logic                   ready_busy_n
);
   typedef enum logic [9:0] {
      S_IDLE  = 10'b00_0000_0001,
      S_RD_A  = 10'b00_0000_0010,
      S_RD_B  = 10'b00_0000_0100,
      S_RD_C  = 10'b00_0000_1000,
      S_RD_D  = 10'b00_0001_0000,
      S_RST   = 10'b00_0010_0000,
      S_WR    = 10'b00_0100_0000,
      S_WIN_A = 10'b00_1000_0000,
      S_ERS   = 10'b01_0000_0000,
      S_WIN_B = 10'b10_0000_0000
   } fws_st_t;

   if (WINDOW_CYC < 1 || WINDOW_CYC > 65535 || SLEEP_CYC < 1 || SLEEP_CYC > 255) begin : g_chk
      $error("fws_ctrl: timer counts out of range");
   end

   localparam int TG = fws_pkg::BIT_TOGGLE;

   fws_st_t                 st_r;
   logic                    issued_r;
   logic                    start_r;
   logic                    check_r;
   logic [2:0]              op_r;
   logic                    skip_r;
   logic [fws_pkg::AW-1:0]  addr_r;
   logic [fws_pkg::DW-1:0]  wdata_r;
   logic [fws_pkg::DW-1:0]  result_r;
   logic [fws_pkg::DW-1:0]  first_r;
   logic                    fail_r;
   logic                    rej_r;
   logic                    ev_done_r;
   logic                    ev_fail_r;
   logic                    ev_rej_r;
   logic [15:0]             win_r;
   logic [7:0]              sleep_r;
   logic                    rb_s1_r;
   logic                    rb_s2_r;
   logic                    rb_s3_r;
   logic [3:0]              irq_stat_r;
   logic [3:0]              irq_mask_r;
   logic [3:0]              irq_set;
   logic                    go;
   logic                    win_open;
   logic                    cyc_done;
   logic [fws_pkg::DW-1:0]  rd;
   fws_pkg::fws_req_t       req;

   ////////////////////////////////////////////////////////////////////////////////
   // pin cycle engine
   fws_pin_cycle u_cyc (
      .ref_clk (ref_clk),
      .reset   (reset),
      .start   (start_r),
      .req     (req),
      .done    (cyc_done),
      .rdata   (rd),
      .pins    (flash_pins),
      .dq_i    (flash_dq_i)
   );

   always_comb begin
      req.write = (st_r == S_WR) || (st_r == S_ERS) || (st_r == S_RST);
      req.addr  = addr_r;
      if (st_r == S_RST) begin
         req.data = RESET_CMD;
      end else if (st_r == S_ERS) begin
         req.data = ERASE_CMD;
      end else begin
         req.data = wdata_r;
      end
   end

   assign go       = reg_wr && (reg_addr == fws_pkg::REG_CTRL) && (st_r == S_IDLE) &&
                     (reg_wdata[2:0] != 3'h0);
   assign win_open = (win_r != 16'h0000);

   ////////////////////////////////////////////////////////////////////////////////
   // software registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         op_r    <= 3'h0;
         skip_r  <= 1'b0;
         addr_r  <= '0;
         wdata_r <= '0;
      end else if (reg_wr) begin
         case (reg_addr)
            fws_pkg::REG_CTRL: begin
               skip_r <= reg_wdata[fws_pkg::CTRL_SKIP_BIT];
               if (go) begin
                  op_r <= reg_wdata[2:0];
               end
            end
            fws_pkg::REG_ADDR:  addr_r  <= reg_wdata[fws_pkg::AW-1:0];
            fws_pkg::REG_WDATA: wdata_r <= reg_wdata[fws_pkg::DW-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= 32'h0000_0000;
         if (reg_rd) begin
            case (reg_addr)
               fws_pkg::REG_CTRL:     reg_rdata <= {28'h0, skip_r, op_r};
               fws_pkg::REG_ADDR:     reg_rdata <= {14'h0, addr_r};
               fws_pkg::REG_WDATA:    reg_rdata <= {24'h0, wdata_r};
               fws_pkg::REG_RESULT:   reg_rdata <= {22'h0, rej_r, fail_r, result_r};
               fws_pkg::REG_STATUS:   reg_rdata <= {28'h0, (sleep_r == 8'(SLEEP_CYC)),
                                                    win_open, rb_s2_r, (st_r != S_IDLE)};
               fws_pkg::REG_IRQ_STAT: reg_rdata <= {28'h0, irq_stat_r};
               fws_pkg::REG_IRQ_MASK: reg_rdata <= {28'h0, irq_mask_r};
               default:               reg_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // operation sequencer
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r      <= S_IDLE;
         issued_r  <= 1'b0;
         start_r   <= 1'b0;
         check_r   <= 1'b0;
         result_r  <= '0;
         first_r   <= '0;
         fail_r    <= 1'b0;
         rej_r     <= 1'b0;
         ev_done_r <= 1'b0;
         ev_fail_r <= 1'b0;
         ev_rej_r  <= 1'b0;
      end else begin
         start_r   <= 1'b0;
         ev_done_r <= 1'b0;
         ev_fail_r <= 1'b0;
         ev_rej_r  <= 1'b0;
         if (st_r == S_IDLE) begin
            issued_r <= 1'b0;
            if (go) begin
               fail_r <= 1'b0;
               rej_r  <= 1'b0;
               case (reg_wdata[2:0])
                  fws_pkg::OP_READ:  st_r <= S_RD_A;
                  fws_pkg::OP_WRITE: st_r <= S_WR;
                  fws_pkg::OP_POLL:  st_r <= S_RD_A;
                  fws_pkg::OP_ERASE_ADD: begin
                     check_r <= !(reg_wdata[fws_pkg::CTRL_SKIP_BIT] && win_open);
                     if (reg_wdata[fws_pkg::CTRL_SKIP_BIT] && win_open) begin
                        st_r <= S_ERS;
                     end else begin
                        st_r <= S_WIN_A;
                     end
                  end
                  default: st_r <= S_IDLE;
               endcase
            end
         end else if (!issued_r) begin
            start_r  <= 1'b1;
            issued_r <= 1'b1;
         end else if (cyc_done) begin
            issued_r <= 1'b0;
            case (st_r)
               S_RD_A: begin
                  result_r <= rd;
                  first_r  <= rd;
                  if (op_r == fws_pkg::OP_READ) begin
                     ev_done_r <= 1'b1;
                     st_r      <= S_IDLE;
                  end else begin
                     st_r <= S_RD_B;
                  end
               end
               S_RD_B: begin
                  result_r <= rd;
                  if (rd[TG] == first_r[TG]) begin
                     ev_done_r <= 1'b1;
                     st_r      <= S_IDLE;
                  end else if (rd[fws_pkg::BIT_FAIL]) begin
                     st_r <= S_RD_C;
                  end else begin
                     st_r <= S_RD_A;
                  end
               end
               S_RD_C: begin
                  first_r <= rd;
                  st_r    <= S_RD_D;
               end
               S_RD_D: begin
                  result_r <= rd;
                  if (rd[TG] == first_r[TG]) begin
                     ev_done_r <= 1'b1;
                     st_r      <= S_IDLE;
                  end else begin
                     fail_r <= 1'b1;
                     st_r   <= S_RST;
                  end
               end
               S_RST: begin
                  ev_fail_r <= 1'b1;
                  ev_done_r <= 1'b1;
                  st_r      <= S_IDLE;
               end
               S_WR: begin
                  ev_done_r <= 1'b1;
                  st_r      <= S_IDLE;
               end
               S_WIN_A: begin
                  result_r <= rd;
                  if (rd[fws_pkg::BIT_WINDOW]) begin
                     rej_r     <= 1'b1;
                     ev_rej_r  <= 1'b1;
                     ev_done_r <= 1'b1;
                     st_r      <= S_IDLE;
                  end else begin
                     st_r <= S_ERS;
                  end
               end
               S_ERS: begin
                  if (check_r) begin
                     st_r <= S_WIN_B;
                  end else begin
                     ev_done_r <= 1'b1;
                     st_r      <= S_IDLE;
                  end
               end
               S_WIN_B: begin
                  result_r <= rd;
                  if (rd[fws_pkg::BIT_WINDOW]) begin
                     rej_r    <= 1'b1;
                     ev_rej_r <= 1'b1;
                  end
                  ev_done_r <= 1'b1;
                  st_r      <= S_IDLE;
               end
               default: st_r <= S_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // erase window timer, restarted by each added sector erase
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         win_r <= 16'h0000;
      end else if ((st_r == S_ERS) && cyc_done) begin
         win_r <= 16'(WINDOW_CYC);
      end else if (win_open) begin
         win_r <= win_r - 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // address held stable while idle lets the flash sleep
   always_ff @(posedge ref_clk) begin
      if (reset || start_r) begin
         sleep_r <= 8'h00;
      end else if (sleep_r != 8'(SLEEP_CYC)) begin
         sleep_r <= sleep_r + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // ready/busy synchroniser
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rb_s1_r <= 1'b1;
         rb_s2_r <= 1'b1;
         rb_s3_r <= 1'b1;
      end else begin
         rb_s1_r <= ready_busy_n;
         rb_s2_r <= rb_s1_r;
         rb_s3_r <= rb_s2_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupts
   always_comb begin
      irq_set                    = 4'h0;
      irq_set[fws_pkg::IRQ_DONE] = ev_done_r;
      irq_set[fws_pkg::IRQ_FAIL] = ev_fail_r;
      irq_set[fws_pkg::IRQ_REJ]  = ev_rej_r;
      irq_set[fws_pkg::IRQ_RDY]  = rb_s2_r && !rb_s3_r;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         irq_stat_r <= 4'h0;
         irq_mask_r <= fws_pkg::IRQ_MASK_RST;
         irq        <= 1'b0;
      end else begin
         if (reg_wr && (reg_addr == fws_pkg::REG_IRQ_STAT)) begin
            irq_stat_r <= (irq_stat_r & ~reg_wdata[3:0]) | irq_set;
         end else begin
            irq_stat_r <= irq_stat_r | irq_set;
         end
         if (reg_wr && (reg_addr == fws_pkg::REG_IRQ_MASK)) begin
            irq_mask_r <= reg_wdata[3:0];
         end
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end
endmodule

// *** tb/fws_flash_model.sv ***
`timescale 1ns/10ps
module fws_flash_model #(
   parameter int WIN_CYC = 200,
   parameter int ERS_CYC = 1000
) (
   // timer clock and pins
   input  wire logic               ref_clk,
   input  wire fws_pkg::fws_pins_t pins,
   input  wire logic               fail_en,
   // outputs
   output logic [7:0]              dq,
   output logic                    rb_low
);
   logic       prog = 1'b0;
   logic       ers  = 1'b0;
   logic       fail = 1'b0;
   logic       tog  = 1'b0;
   logic       sec  = 1'b0;
   logic [7:0] wb   = 8'h0;
   logic [7:0] last = 8'h0;
   logic [7:0] drv;
   int         left = 0;
   int         win  = 0;
   wire        wflag = ers && win <= 0;
   assign drv = prog ? {~wb[7], tog, fail, 5'h0} :
                ers ? {1'b0, tog, 2'h0, wflag, sec, 2'h0} : pins.addr[7:0] ^ 8'h5a;
   // released bus shows the inverse of the last byte
   assign dq = pins.oe_n ? ~last : drv;
   assign rb_low = prog || ers;
   always @(posedge pins.oe_n) last = drv;
   always @(negedge pins.oe_n) begin
      if (prog || ers) begin
         tog = ~tog;
         sec = ~sec;
      end
      if (prog) begin
         left = left - 1;
         fail = fail_en && left <= 0;
         prog = fail_en || left > 0;
      end
   end
   always @(negedge pins.we_n) begin
      if (pins.dq_o == fws_pkg::CMD_RESET && !wflag) begin
         prog = 1'b0;
         fail = 1'b0;
      end else if (pins.dq_o == fws_pkg::CMD_SECTOR_ERASE && !wflag) begin
         ers = 1'b1;
         win = WIN_CYC;
      end else if (!ers && !prog) begin
         prog = 1'b1;
         wb   = pins.dq_o;
         left = 3;
      end
   end
   // timer steps off the sampling edge so the host never races the status byte
   always @(negedge ref_clk) begin
      if (ers) begin
         win = win - 1;
         ers = win > -ERS_CYC;
      end
   end
endmodule

// *** tb/fws_ctrl_props.sv ***
`timescale 1ns/10ps
module fws_ctrl_props #(parameter int WINDOW_CYC = 5000, parameter int SLEEP_CYC = 12) (
   // clock and reset
   input wire logic               ref_clk,
   input wire logic               reset,
   // register port and pins
   input wire logic [2:0]         reg_addr,
   input wire logic [31:0]        reg_wdata,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire logic [31:0]        reg_rdata,
   input wire logic               irq,
   input wire fws_pkg::fws_pins_t flash_pins
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its slot");
   pin_excl_a: assert property (!(!flash_pins.we_n && !flash_pins.oe_n))
      else $error("write and output enable low together");
   read_len_a: assert property ($fell(flash_pins.oe_n) |->
      (!flash_pins.oe_n)[*8] ##1 (!flash_pins.oe_n)[*3] ##1 flash_pins.oe_n)
      else $error("read strobe length wrong");
   write_len_a: assert property ($fell(flash_pins.we_n) |->
      (!flash_pins.we_n && flash_pins.dq_oe)[*5] ##1 flash_pins.we_n ##1 !flash_pins.dq_oe)
      else $error("write strobe length wrong");
   bus_turn_a: assert property (!flash_pins.oe_n |-> !flash_pins.dq_oe)
      else $error("data driven during read");
   addr_hold_a: assert property (!flash_pins.ce_n && !$past(flash_pins.ce_n)
      |-> $stable(flash_pins.addr)) else $error("address moved in cycle");
   irq_mask_a: assert property (reg_wr && reg_addr == 3'h6 && reg_wdata[3:0] == 4'h0
      |-> ##2 !irq) else $error("masked interrupt raised");
   reset_idle_a: assert property (disable iff (1'b0) reset |=>
      flash_pins.ce_n && flash_pins.oe_n && flash_pins.we_n) else $error("pins busy in reset");
   cover property ($fell(flash_pins.oe_n));
   cover property ($fell(flash_pins.we_n));
   cover property ($rose(irq));
   cover property ($fell(flash_pins.we_n) && flash_pins.dq_o == 8'h30);
endmodule
////////////////////////////////////////
bind fws_ctrl fws_ctrl_props #(.WINDOW_CYC(WINDOW_CYC), .SLEEP_CYC(SLEEP_CYC)) fws_ctrl_props_inst (
   .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .flash_pins(flash_pins));

// *** tb/fws_ctrl_tb.sv ***
`timescale 1ns/10ps
module fws_ctrl_tb;
   logic               ref_clk   = 1'b0;
   logic               reset     = 1'b1;
   logic               reg_wr    = 1'b0;
   logic               reg_rd    = 1'b0;
   logic               fail_en   = 1'b0;
   logic [2:0]         reg_addr  = 3'h0;
   logic [31:0]        reg_wdata = 32'h0;
   logic [31:0]        reg_rdata;
   logic [31:0]        rv;
   logic               irq;
   logic               rb_low;
   logic [7:0]         dq;
   int                 n_fail    = 0;
   int                 tests_run = 0;
   fws_pkg::fws_pins_t pins;
   initial forever #5 ref_clk = ~ref_clk;
   fws_ctrl #(.WINDOW_CYC(200)) fws_ctrl_inst (
      .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .flash_pins(pins), .flash_dq_i(dq), .ready_busy_n(~rb_low));
   fws_flash_model #(.WIN_CYC(200)) fws_flash_model_inst (
      .ref_clk(ref_clk), .pins(pins), .fail_en(fail_en), .dq(dq), .rb_low(rb_low));
   ////////////////////////////////////////
   task automatic final_report;
      if (n_fail == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      @(negedge ref_clk);
      rv = reg_rdata;
   endtask
   task automatic rc(input logic [2:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a);
      chk(rv & m, e);
   endtask
   // start an operation, then poll until the controller is idle
   task automatic go(input logic [31:0] c);
      int i;
      wr(fws_pkg::REG_CTRL, c);
      for (i = 0; i < 300; i++) begin
         rd(fws_pkg::REG_STATUS);
         if (rv[0] === 1'b0) break;
      end
      if (i == 300) begin
         n_fail++;
         final_report();
      end
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      rc(3'h7, 32'hffffffff, 32'h0);
      rc(fws_pkg::REG_IRQ_MASK, 32'hffffffff, 32'h0);
      wr(fws_pkg::REG_IRQ_MASK, 32'hf);
      wr(fws_pkg::REG_ADDR, 32'h12);
      go(fws_pkg::OP_READ);
      rc(fws_pkg::REG_RESULT, 32'hffffffff, 32'h48);
      repeat (20) @(posedge ref_clk);
      rc(fws_pkg::REG_STATUS, 32'hf, 32'ha);
      wr(fws_pkg::REG_WDATA, 32'h80);
      go(fws_pkg::OP_WRITE);
      rc(fws_pkg::REG_STATUS, 32'h2, 32'h0);
      go(fws_pkg::OP_POLL);
      rc(fws_pkg::REG_RESULT, 32'h300, 32'h0);
      rc(fws_pkg::REG_IRQ_STAT, 32'hf, 32'h9);
      wr(fws_pkg::REG_IRQ_STAT, 32'hf);
      rc(fws_pkg::REG_IRQ_STAT, 32'hf, 32'h0);
      chk({31'h0, irq}, 32'h0);
      fail_en <= 1'b1;
      go(fws_pkg::OP_WRITE);
      go(fws_pkg::OP_POLL);
      rc(fws_pkg::REG_RESULT, 32'h100, 32'h100);
      rc(fws_pkg::REG_STATUS, 32'h2, 32'h2);
      rc(fws_pkg::REG_IRQ_STAT, 32'hf, 32'hb);
      chk({31'h0, irq}, 32'h1);
      fail_en <= 1'b0;
      wr(fws_pkg::REG_IRQ_STAT, 32'hf);
      wr(fws_pkg::REG_ADDR, 32'h2008);
      go(fws_pkg::OP_ERASE_ADD);
      rc(fws_pkg::REG_RESULT, 32'h200, 32'h0);
      go(fws_pkg::OP_ERASE_ADD);
      rc(fws_pkg::REG_RESULT, 32'h200, 32'h0);
      go(fws_pkg::OP_ERASE_ADD | 32'h8);
      rc(fws_pkg::REG_CTRL, 32'hf, 32'hc);
      rc(fws_pkg::REG_RESULT, 32'h200, 32'h0);
      repeat (150) @(posedge ref_clk);
      rc(fws_pkg::REG_STATUS, 32'h4, 32'h4);
      wr(fws_pkg::REG_IRQ_MASK, 32'h0);
      repeat (100) @(posedge ref_clk);
      rc(fws_pkg::REG_STATUS, 32'h4, 32'h0);
      go(fws_pkg::OP_ERASE_ADD);
      rc(fws_pkg::REG_RESULT, 32'h200, 32'h200);
      rc(fws_pkg::REG_IRQ_STAT, 32'h4, 32'h4);
      chk({31'h0, irq}, 32'h0);
      wr(fws_pkg::REG_IRQ_MASK, 32'hf);
      rd(fws_pkg::REG_STATUS);
      chk({31'h0, irq}, 32'h1);
      final_report();
   end
endmodule
